// *** rtl/rso_reset_supervisor.sv ***
// Reset output sequencer with undervoltage, watchdog and soft reset sources
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - A reset condition pulls the output low only after it has lasted the filter time.
// - The output stays low while the condition lasts and for one delay time after it ends.
// - After power-up the output is low and rises one delay time after the regulator is good.
// - A watchdog failure is a reset condition just like undervoltage.
// - The threshold select is set over SPI and resets to the lowest falling threshold.
// - A soft reset returns the chip to init mode (restart or fail-safe if a watchdog failure rises in the same cycle) and restores the config to defaults.
// - A config bit selects whether a soft reset also pulses the output for a delay time.
// - A soft reset is honoured only in normal or stop mode and ignored otherwise.
// - A watchdog failure pulls the output low and enters restart or fail-safe mode.
// - SPI commands act only when the select input returns high.
module rso_reset_supervisor #(
    parameter int FILTER_CYC = rso_pkg::RESET_FILTER_CYC,
    parameter int DELAY_CYC = rso_pkg::RESET_DELAY_CYC
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic UV_DETECT,
    input wire logic WD_FAIL,
    input wire logic WD_FAIL_TO_FAILSAFE,
    input wire logic SPI_SELECT_N,
    input wire rso_pkg::rso_spi_cmd_t SPI_CMD,
    output logic RESET_OUT_N,
    output rso_pkg::rso_mode_t MODE,
    output logic [1:0] THRESHOLD_SEL,
    output logic SOFT_RESET_DRIVES_PIN,
    output logic REGS_TO_DEFAULT
);

    localparam int CW = $clog2(DELAY_CYC > FILTER_CYC ? DELAY_CYC + 1 : FILTER_CYC + 1);

    // Zero counts would end a phase only after the counter wraps
    if (FILTER_CYC < 1 || DELAY_CYC < 1)
    begin : g_bad_counts
        $error("Filter and delay counts must be at least one");
    end

    rso_pkg::rso_state_t st_q, st_d;
    rso_pkg::rso_mode_t mode_q, mode_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic sel_n_q;
    logic soft_pin_q;
    logic [1:0] thr_q;
    logic wd_seen_q;
    logic out_n_q;

    wire frame_end = SPI_SELECT_N && !sel_n_q;
    wire soft_req = frame_end && SPI_CMD.mode_wr
        && SPI_CMD.mode_field == rso_pkg::MODE_FIELD_SOFT_RESET
        && (mode_q == rso_pkg::MODE_NORMAL || mode_q == rso_pkg::MODE_STOP);
    wire soft_pulse = soft_req && soft_pin_q;
    wire cond = UV_DETECT || WD_FAIL;
    wire [CW-1:0] filt_last = CW'(FILTER_CYC - 1);
    wire [CW-1:0] dly_last = CW'(DELAY_CYC - 1);
    wire cnt_done_f = cnt_q == filt_last;
    wire cnt_done_d = cnt_q == dly_last;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q + CW'(1);
        case (st_q)
            rso_pkg::ST_DELAY:
            begin
                if (cond)
                begin
                    st_d = rso_pkg::ST_LOW;
                    cnt_d = '0;
                end
                else if (cnt_done_d)
                begin
                    st_d = rso_pkg::ST_HIGH;
                    cnt_d = '0;
                end
            end
            rso_pkg::ST_HIGH:
            begin
                cnt_d = '0;
                if (soft_pulse)
                begin
                    st_d = rso_pkg::ST_DELAY;
                end
                else if (cond)
                begin
                    st_d = rso_pkg::ST_FILTER;
                end
            end
            rso_pkg::ST_FILTER:
            begin
                // Pin still high here, so a soft reset must pulse it too
                if (soft_pulse)
                begin
                    st_d = rso_pkg::ST_DELAY;
                    cnt_d = '0;
                end
                else if (!cond)
                begin
                    st_d = rso_pkg::ST_HIGH;
                    cnt_d = '0;
                end
                else if (cnt_done_f)
                begin
                    st_d = rso_pkg::ST_LOW;
                    cnt_d = '0;
                end
            end
            rso_pkg::ST_LOW:
            begin
                cnt_d = '0;
                if (!cond)
                begin
                    st_d = rso_pkg::ST_DELAY;
                end
            end
            default:
            begin
                st_d = rso_pkg::ST_LOW;
                cnt_d = '0;
            end
        endcase
    end

    wire wd_rise = WD_FAIL && !wd_seen_q;
    wire out_n_d = st_d == rso_pkg::ST_HIGH || st_d == rso_pkg::ST_FILTER;

    always_comb
    begin
        mode_d = mode_q;
        if (wd_rise)
        begin
            mode_d = WD_FAIL_TO_FAILSAFE ? rso_pkg::MODE_FAILSAFE : rso_pkg::MODE_RESTART;
        end
        // Back to init on soft reset
        else if (soft_req)
        begin
            mode_d = rso_pkg::MODE_INIT;
        end
        else if (frame_end && SPI_CMD.mode_wr)
        begin
            case (SPI_CMD.mode_field)
                rso_pkg::MODE_FIELD_NORMAL: mode_d = rso_pkg::MODE_NORMAL;
                rso_pkg::MODE_FIELD_SLEEP: mode_d = rso_pkg::MODE_SLEEP;
                rso_pkg::MODE_FIELD_STOP: mode_d = rso_pkg::MODE_STOP;
                default: mode_d = mode_q;
            endcase
        end
        // Restart leaves once the output rises
        else if (mode_q == rso_pkg::MODE_RESTART && st_q == rso_pkg::ST_HIGH)
        begin
            mode_d = rso_pkg::MODE_NORMAL;
        end
    end

    // Power-on is the reset; output low from the first instant
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st_q <= rso_pkg::ST_LOW;
            cnt_q <= '0;
            mode_q <= rso_pkg::MODE_INIT;
            sel_n_q <= 1'b1;
            wd_seen_q <= 1'b0;
            out_n_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            sel_n_q <= SPI_SELECT_N;
            wd_seen_q <= WD_FAIL;
            out_n_q <= out_n_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            soft_pin_q <= rso_pkg::SOFT_DRIVES_PIN_RST;
            thr_q <= rso_pkg::THRESHOLD_RST;
        end
        else if (soft_req)
        begin
            soft_pin_q <= rso_pkg::SOFT_DRIVES_PIN_RST;
            thr_q <= rso_pkg::THRESHOLD_RST;
        end
        else if (frame_end && SPI_CMD.cfg_wr)
        begin
            soft_pin_q <= SPI_CMD.cfg_soft_drives_pin;
            thr_q <= SPI_CMD.cfg_threshold;
        end
    end

    // From a flop so the pin cannot glitch between states
    assign RESET_OUT_N = out_n_q;
    assign MODE = mode_q;
    assign THRESHOLD_SEL = thr_q;
    assign SOFT_RESET_DRIVES_PIN = soft_pin_q;
    assign REGS_TO_DEFAULT = soft_req;

    int unsigned lo_cnt;
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            lo_cnt <= 0;
        else if (!RESET_OUT_N && !cond)
            lo_cnt <= lo_cnt + 1;
        else
            lo_cnt <= 0;
    end

    property p_filter;
        @(posedge REF_CLK) disable iff (!RSTN)
        (RESET_OUT_N && !cond && !soft_pulse) ##1 cond |-> RESET_OUT_N;
    endproperty
    a_filter: assert property (p_filter) else $error("Output fell without filter");

    property p_hold;
        @(posedge REF_CLK) disable iff (!RSTN)
        (!RESET_OUT_N && cond) |=> !RESET_OUT_N;
    endproperty
    a_hold: assert property (p_hold) else $error("Output rose while condition held");

    property p_delay;
        @(posedge REF_CLK) disable iff (!RSTN)
        $rose(RESET_OUT_N) |-> lo_cnt >= DELAY_CYC;
    endproperty
    a_delay: assert property (p_delay) else $error("Output rose before delay");

    property p_wd;
        @(posedge REF_CLK) disable iff (!RSTN)
        wd_rise |=> mode_q == rso_pkg::MODE_RESTART || mode_q == rso_pkg::MODE_FAILSAFE;
    endproperty
    a_wd: assert property (p_wd) else $error("Watchdog failure did not change mode");

    property p_soft;
        @(posedge REF_CLK) disable iff (!RSTN)
        soft_req && !wd_rise |=> mode_q == rso_pkg::MODE_INIT && soft_pin_q
            && thr_q == rso_pkg::THRESHOLD_RST;
    endproperty
    a_soft: assert property (p_soft) else $error("Soft reset did not restore defaults");

    property p_soft_pin;
        @(posedge REF_CLK) disable iff (!RSTN)
        soft_req && soft_pin_q && RESET_OUT_N && !cond |=> !RESET_OUT_N;
    endproperty
    a_soft_pin: assert property (p_soft_pin) else $error("Soft reset did not pulse pin");

    property p_mode_gate;
        @(posedge REF_CLK) disable iff (!RSTN)
        frame_end && SPI_CMD.mode_wr && SPI_CMD.mode_field == rso_pkg::MODE_FIELD_SOFT_RESET
            && mode_q != rso_pkg::MODE_NORMAL && mode_q != rso_pkg::MODE_STOP && !wd_rise
            |-> !REGS_TO_DEFAULT ##1 $stable(mode_q);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("Soft reset not ignored");

    property p_select;
        @(posedge REF_CLK) disable iff (!RSTN)
        !SPI_SELECT_N |=> $stable(thr_q) && $stable(soft_pin_q);
    endproperty
    a_select: assert property (p_select) else $error("Config changed inside frame");

endmodule : rso_reset_supervisor

`default_nettype wire

// *** rtl/rso_pkg.sv ***
// Package for the reset output and soft reset supervisor
package rso_pkg;

    // Device modes
    typedef enum logic [5:0] {
        MODE_INIT     = 6'h01,
        MODE_NORMAL   = 6'h02,
        MODE_STOP     = 6'h04,
        MODE_SLEEP    = 6'h08,
        MODE_RESTART  = 6'h10,
        MODE_FAILSAFE = 6'h20
    } rso_mode_t;

    // Reset output sequencer states
    typedef enum logic [3:0] {
        ST_DELAY  = 4'h1,
        ST_HIGH   = 4'h2,
        ST_FILTER = 4'h4,
        ST_LOW    = 4'h8
    } rso_state_t;

    // Decoded SPI frame handed over at select release
    typedef struct packed {
        logic       mode_wr;
        logic [1:0] mode_field;
        logic       cfg_wr;
        logic       cfg_soft_drives_pin;
        logic [1:0] cfg_threshold;
    } rso_spi_cmd_t;

    localparam logic [1:0] MODE_FIELD_NORMAL = 2'h0;
    localparam logic [1:0] MODE_FIELD_SLEEP = 2'h1;
    localparam logic [1:0] MODE_FIELD_STOP = 2'h2;
    localparam logic [1:0] MODE_FIELD_SOFT_RESET = 2'h3;

    // Reset values of the configuration held here
    localparam logic SOFT_DRIVES_PIN_RST = 1'b1;
    localparam logic [1:0] THRESHOLD_RST = 2'h0;

    // Timing: filter and delay in ns, counts at 250 MHz
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_FILTER_TIME_NS = 10000;
    localparam int RESET_DELAY_TIME_NS = 10000000;
    localparam int RESET_FILTER_CYC = (RESET_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : rso_pkg

// *** dv/rso_host_model.sv ***
// Host model issuing SPI frames to the supervisor
`timescale 1ns/1ps
`default_nettype none
module rso_host_model (
    input wire logic REF_CLK,
    output logic SPI_SELECT_N,
    output rso_pkg::rso_spi_cmd_t SPI_CMD
);
    initial
    begin
        SPI_SELECT_N = 1'b1;
        SPI_CMD = '0;
    end
    task automatic open(input rso_pkg::rso_spi_cmd_t c);
        @(negedge REF_CLK);
        SPI_CMD = c;
        SPI_SELECT_N = 1'b0;
        repeat (3) @(negedge REF_CLK);
    endtask : open
    task automatic close();
        SPI_SELECT_N = 1'b1;
        repeat (2) @(negedge REF_CLK);
        // Released lines show junk, not the last value
        SPI_CMD = ~SPI_CMD;
    endtask : close
endmodule : rso_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the reset supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int FC = 4;
    localparam int DC = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic uv = 1'b1;
    logic wd = 1'b0;
    logic wdfs = 1'b0;
    logic sel_n;
    rso_pkg::rso_spi_cmd_t cmd;
    logic rout_n;
    rso_pkg::rso_mode_t mode;
    logic [1:0] thr;
    logic sdp;
    logic rtd;
    int mismatches = 0;
    int n_compared = 0;
    int pulses = 0;
    int lows = 0;
    int n;
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        if (rtd === 1'b1) pulses <= pulses + 1;
        if (rout_n !== 1'b1) lows <= lows + 1;
    end
    rso_host_model host (.REF_CLK(clk), .SPI_SELECT_N(sel_n), .SPI_CMD(cmd));
    rso_reset_supervisor #(.FILTER_CYC(FC), .DELAY_CYC(DC)) dut (
        .REF_CLK(clk), .RSTN(rstn), .UV_DETECT(uv), .WD_FAIL(wd),
        .WD_FAIL_TO_FAILSAFE(wdfs), .SPI_SELECT_N(sel_n), .SPI_CMD(cmd),
        .RESET_OUT_N(rout_n), .MODE(mode), .THRESHOLD_SEL(thr),
        .SOFT_RESET_DRIVES_PIN(sdp), .REGS_TO_DEFAULT(rtd));
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait for the output level, n counts cycles
    task automatic wait_out(input logic v, input int lim);
        n = 0;
        while (rout_n !== v)
        begin
            @(negedge clk);
            n++;
            if (n > lim)
            begin
                chk("out wait", 6'(v), 6'(rout_n));
                end_of_test();
            end
        end
    endtask : wait_out
    task automatic send(input logic [1:0] mf, input logic cw, input logic pin,
        input logic [1:0] th);
        host.open(rso_pkg::rso_spi_cmd_t'({1'b1, mf, cw, pin, th}));
        host.close();
    endtask : send
    task automatic t_power();
        chk("out in reset", 6'h0, 6'(rout_n));
        chk("mode in reset", rso_pkg::MODE_INIT, mode);
        chk("thr default", 6'h0, 6'(thr));
        chk("pin default", 6'h1, 6'(sdp));
        rstn = 1'b1;
        repeat (3 * DC) @(negedge clk);
        chk("out while low supply", 6'h0, 6'(rout_n));
        uv = 1'b0;
        wait_out(1'b1, DC + 3);
        chk("power delay", 6'h1, 6'(n >= DC));
    endtask : t_power
    task automatic t_filter();
        uv = 1'b1;
        repeat (FC - 2) @(negedge clk);
        uv = 1'b0;
        repeat (FC + 2) @(negedge clk);
        chk("glitch ignored", 6'h1, 6'(rout_n));
        uv = 1'b1;
        wait_out(1'b0, FC + 3);
        chk("filter time", 6'h1, 6'(n >= FC));
        repeat (2 * DC) @(negedge clk);
        chk("held while cond", 6'h0, 6'(rout_n));
        uv = 1'b0;
        wait_out(1'b1, DC + 3);
        chk("release delay", 6'h1, 6'(n >= DC));
    endtask : t_filter
    task automatic t_spi();
        host.open(rso_pkg::rso_spi_cmd_t'({1'b1, rso_pkg::MODE_FIELD_NORMAL, 1'b1, 1'b0, 2'h2}));
        chk("mode in frame", rso_pkg::MODE_INIT, mode);
        chk("thr in frame", 6'h0, 6'(thr));
        host.close();
        chk("mode after", rso_pkg::MODE_NORMAL, mode);
        chk("thr written", 6'h2, 6'(thr));
        chk("pin written", 6'h0, 6'(sdp));
    endtask : t_spi
    task automatic t_soft();
        int l0 = lows;
        int p0 = pulses;
        send(rso_pkg::MODE_FIELD_SOFT_RESET, 1'b0, 1'b0, 2'h0);
        repeat (DC + 2) @(negedge clk);
        chk("mode soft", rso_pkg::MODE_INIT, mode);
        chk("thr restored", 6'h0, 6'(thr));
        chk("pin restored", 6'h1, 6'(sdp));
        chk("defaults pulse", 6'h1, 6'(pulses - p0));
        chk("pin untouched", 6'h0, 6'(lows - l0));
        send(rso_pkg::MODE_FIELD_NORMAL, 1'b0, 1'b0, 2'h0);
        send(rso_pkg::MODE_FIELD_STOP, 1'b0, 1'b0, 2'h0);
        chk("mode stop", rso_pkg::MODE_STOP, mode);
        host.open(rso_pkg::rso_spi_cmd_t'({1'b1, rso_pkg::MODE_FIELD_SOFT_RESET, 4'h0}));
        host.close();
        chk("out low soft", 6'h0, 6'(rout_n));
        chk("mode soft stop", rso_pkg::MODE_INIT, mode);
        wait_out(1'b1, DC + 3);
        chk("soft delay", 6'h1, 6'(n >= DC - 1));
    endtask : t_soft
    task automatic t_ignore();
        int p0 = pulses;
        send(rso_pkg::MODE_FIELD_SOFT_RESET, 1'b1, 1'b1, 2'h0);
        send(rso_pkg::MODE_FIELD_NORMAL, 1'b1, 1'b1, 2'h3);
        send(rso_pkg::MODE_FIELD_SLEEP, 1'b0, 1'b0, 2'h0);
        chk("mode sleep", rso_pkg::MODE_SLEEP, mode);
        send(rso_pkg::MODE_FIELD_SOFT_RESET, 1'b0, 1'b0, 2'h0);
        chk("sleep kept", rso_pkg::MODE_SLEEP, mode);
        chk("thr kept", 6'h3, 6'(thr));
        chk("no pulse", 6'h0, 6'(pulses - p0));
        chk("out kept", 6'h1, 6'(rout_n));
    endtask : t_ignore
    task automatic t_wd(input logic fs, input rso_pkg::rso_mode_t m);
        wdfs = fs;
        send(rso_pkg::MODE_FIELD_NORMAL, 1'b0, 1'b0, 2'h0);
        wd = 1'b1;
        wait_out(1'b0, FC + 3);
        chk("wd mode", m, mode);
        wd = 1'b0;
        wait_out(1'b1, DC + 3);
        chk("wd delay", 6'h1, 6'(n >= DC));
    endtask : t_wd
    initial
    begin
        repeat (2) @(negedge clk);
        t_power();
        t_filter();
        t_spi();
        t_soft();
        t_ignore();
        // Second reset in mid-run leaves sleep
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk("out in 2nd reset", 6'h0, 6'(rout_n));
        chk("mode in 2nd reset", rso_pkg::MODE_INIT, mode);
        chk("thr in 2nd reset", 6'h0, 6'(thr));
        rstn = 1'b1;
        @(negedge clk);
        chk("out after release", 6'h0, 6'(rout_n));
        wait_out(1'b1, DC + 3);
        t_wd(1'b0, rso_pkg::MODE_RESTART);
        repeat (2) @(negedge clk);
        chk("restart to normal", rso_pkg::MODE_NORMAL, mode);
        t_wd(1'b1, rso_pkg::MODE_FAILSAFE);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
